//--- sdrs_pkg.sv
// Package with register map, reset values, timing constants and carrier types of the register set.
package sdrs_pkg;

    localparam int          ADR_W          = 9;
    localparam int          CLK_HZ         = 25_000_000;
    // Register indices; the byte address on the bus is four times the index.
    localparam logic [6:0]  IDX_CHOP       = 7'h6C;
    localparam logic [6:0]  IDX_COOL       = 7'h6D;
    localparam logic [6:0]  IDX_COMM       = 7'h6E;
    localparam logic [6:0]  IDX_FLAGS      = 7'h6F;
    localparam logic [6:0]  IDX_VPWM       = 7'h70;
    localparam logic [6:0]  IDX_AMPL       = 7'h71;
    localparam logic [6:0]  IDX_AUTO       = 7'h72;
    localparam logic [6:0]  IDX_LOST       = 7'h73;
    // Implemented widths of the registers.
    localparam int          COOL_W         = 25;
    localparam int          COMM_W         = 24;
    localparam int          LOST_W         = 20;
    // Reset values.
    localparam logic [31:0] CHOP_RST       = 32'h10410150;
    localparam logic [31:0] VPWM_RST       = 32'hC40C001E;
    localparam logic [24:0] COOL_RST       = 25'h0000000;
    localparam logic [23:0] COMM_RST       = 24'h000000;
    // Field positions inside the commutation timing control word.
    localparam int          ON_TIME_LSB    = 0;
    localparam int          ON_TIME_W      = 10;
    localparam int          LOSS_LSB       = 16;
    localparam int          LOSS_W         = 8;
    // Step-loss limit unit in clock periods, and the resulting counter width.
    localparam int          LOSS_SCALE     = 16;
    localparam int          LOSS_SHIFT     = 4;
    localparam int          ON_CNT_W       = LOSS_W + LOSS_SHIFT;
    // Field positions inside the amplitude and auto-tuning result words.
    localparam int          AMPL_SCALE_LSB = 0;
    localparam int          AMPL_OFS_LSB   = 16;
    localparam int          AUTO_OFS_LSB   = 0;
    localparam int          AUTO_GRAD_LSB  = 16;
    // Default sine table: amplitude and full-wave length.
    localparam int          SINE_AMPL      = 248;
    localparam int          SINE_STEPS     = 1024;
    localparam int          SINE_QUARTER   = 256;

    typedef struct packed {
        logic              cyc;
        logic              stb;
        logic              we;
        logic [ADR_W-1:0]  adr;
        logic [3:0]        sel;
        logic [31:0]       dat;
    } sdrs_wb_req_t;

    typedef struct packed {
        logic [31:0]       load_flags;
        logic [7:0]        ampl_scale;
        logic [8:0]        ampl_offset;
        logic [7:0]        auto_offset;
        logic [7:0]        auto_gradient;
    } sdrs_result_t;

    typedef struct packed {
        logic              step;
        logic              dir;
        logic              commutation_ready_output;
        logic              step_direction_select;
        logic              commutation_mode_enable_pin;
        logic              pwm_on;
        logic              high_velocity_fullstep;
        logic [22:0]       velocity;
        logic [22:0]       commutation_mode_min_velocity;
        logic [22:0]       high_velocity_threshold;
    } sdrs_motion_t;

endpackage : sdrs_pkg

//--- sdrs_regs.sv
// Register set of the stepper driver: bus slave, commutation timing limits and lost-step counter.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - On-time limit is commutation word bits 9:0, counted in clock periods.
// - Step-loss limit is bits 23:16 times sixteen periods; zero disables detection.
// - Commutation mode is enabled by its pin or by the minimum velocity threshold.
// - Step-loss detection also works above high threshold with fullstep switching.
// - Amplitude result bits 7:0 report voltage scaling, read-only, 255 is maximum.
// - Amplitude result holds nine-bit signed duty offset spanning -255 to +255.
// - Auto result bits 7:0 report automatically found PWM offset, read-only.
// - Auto result bits 23:16 report automatically found PWM gradient.
// - Count step pulses arriving in commutation mode while the ready output is low.
// - Lost-step counter is 20 bits, wraps, follows direction, only in step/dir mode.
// - Default table entry i is round(248*sin(2*pi*i/1024+pi/1024)) minus one.
// - Default waveform peaks at +247 and -248.
// - Rounding of the default table is half up.
// - Chopper configuration is read/write, 32 bits, reset 0x10410150.
// - Voltage chopper configuration is write-only, 32 bits, reset 0xC40C001E.
// - Read-only 32-bit status carries load measurement and driver error flags.
// - Write-only 25-bit register holds current control and load detection setup.
module sdrs_regs #(
    parameter int TAB_IDX_W = 10
) (
    input  wire logic                   SYS_CLK,
    input  wire logic                   RST,
    input  wire sdrs_pkg::sdrs_wb_req_t WB_REQ,
    output logic                        WB_ACK,
    output logic [31:0]                 WB_DAT_O,
    input  wire sdrs_pkg::sdrs_result_t RESULTS,
    input  wire sdrs_pkg::sdrs_motion_t MOTION,
    input  wire logic [TAB_IDX_W-1:0]   TABLE_POS,
    output logic [8:0]                  TABLE_VALUE,
    output logic [31:0]                 CHOP_CONFIG,
    output logic [24:0]                 COOL_CONFIG,
    output logic [31:0]                 VPWM_CONFIG,
    output logic                        COMMUTATION_MODE_ACTIVE,
    output logic                        STEP_LOSS_DETECT_ENABLE,
    output logic                        PWM_ON_CUT,
    output logic                        STEP_LOSS_DETECTED
);
    import sdrs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Default sine table, evaluated at elaboration time.

    function automatic int sine_entry(input int i);
        real y;
        y = $itor(SINE_AMPL) * $sin(2.0 * 3.14159265358979 * $itor(i) / $itor(SINE_STEPS)
            + 3.14159265358979 / $itor(SINE_STEPS));
        return int'($floor(y + 0.5)) - 1;
    endfunction : sine_entry

    function automatic logic [31:0] lane_merge(input logic [31:0] old_val,
                                               input logic [31:0] new_val,
                                               input logic [3:0]  sel);
        logic [31:0] r;
        r = old_val;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = new_val[8*b +: 8];
            end
        end
        return r;
    endfunction : lane_merge

    logic [7:0] quarter_tab [SINE_QUARTER];

    for (genvar g = 0; g < SINE_QUARTER; g++) begin : g_tab
        localparam int V = sine_entry(g);
        assign quarter_tab[g] = V[7:0];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State.

    typedef struct packed {
        logic                ack;
        logic [31:0]         dat;
        logic [31:0]         chop;
        logic [COOL_W-1:0]   cool;
        logic [COMM_W-1:0]   comm;
        logic [31:0]         vpwm;
        logic [LOST_W-1:0]   lost;
        logic                step_prev;
        logic [ON_CNT_W-1:0] on_cnt;
        logic                cut;
        logic                loss;
        logic [8:0]          tab;
    } sdrs_state_t;

    sdrs_state_t state_reg;
    sdrs_state_t state_next;

    logic [6:0]            idx;
    logic                  req_new;
    logic                  comm_active;
    logic                  loss_enable;
    logic [ON_TIME_W-1:0]  on_time_limit;
    logic [LOSS_W-1:0]     loss_limit;
    logic [ON_CNT_W-1:0]   loss_cycles;
    logic                  step_edge;
    logic [7:0]            quarter_idx;
    logic [7:0]            mag;

    ////////////////////////////////////////////////////////////////////////////////
    // Commutation timing.

    assign on_time_limit = state_reg.comm[ON_TIME_LSB +: ON_TIME_W];
    assign loss_limit    = state_reg.comm[LOSS_LSB +: LOSS_W];
    assign loss_cycles   = {loss_limit, {LOSS_SHIFT{1'b0}}};

    // A zero minimum velocity means the threshold path is switched off.
    assign comm_active = MOTION.commutation_mode_enable_pin
        || ((MOTION.commutation_mode_min_velocity != 23'h000000)
            && (MOTION.velocity >= MOTION.commutation_mode_min_velocity));

    assign loss_enable = (loss_limit != 8'h00)
        && (comm_active
            || (MOTION.high_velocity_fullstep
                && (MOTION.velocity >= MOTION.high_velocity_threshold)));

    assign step_edge = MOTION.step && !state_reg.step_prev;

    ////////////////////////////////////////////////////////////////////////////////
    // Full-wave lookup built from the quarter table by symmetry.

    assign quarter_idx = TABLE_POS[8] ? ~TABLE_POS[7:0] : TABLE_POS[7:0];
    assign mag         = quarter_tab[quarter_idx];

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode and next state.

    assign idx     = WB_REQ.adr[ADR_W-1:2];
    assign req_new = WB_REQ.cyc && WB_REQ.stb && !state_reg.ack;

    always_comb begin
        state_next           = state_reg;
        state_next.ack       = req_new;
        state_next.step_prev = MOTION.step;

        if (req_new && WB_REQ.we) begin
            // Read-only and unmapped indices fall through and are ignored.
            if (idx == IDX_CHOP) begin
                state_next.chop = lane_merge(state_reg.chop, WB_REQ.dat, WB_REQ.sel);
            end else if (idx == IDX_COOL) begin
                state_next.cool = COOL_W'(lane_merge({7'h00, state_reg.cool}, WB_REQ.dat,
                                                     WB_REQ.sel));
            end else if (idx == IDX_COMM) begin
                state_next.comm = COMM_W'(lane_merge({8'h00, state_reg.comm}, WB_REQ.dat,
                                                     WB_REQ.sel));
            end else if (idx == IDX_VPWM) begin
                state_next.vpwm = lane_merge(state_reg.vpwm, WB_REQ.dat, WB_REQ.sel);
            end
        end

        state_next.dat = 32'h00000000;
        if (req_new && !WB_REQ.we) begin
            if (idx == IDX_CHOP) begin
                state_next.dat = state_reg.chop;
            end else if (idx == IDX_FLAGS) begin
                state_next.dat = RESULTS.load_flags;
            end else if (idx == IDX_AMPL) begin
                state_next.dat[AMPL_SCALE_LSB +: 8] = RESULTS.ampl_scale;
                state_next.dat[AMPL_OFS_LSB +: 9]   = RESULTS.ampl_offset;
            end else if (idx == IDX_AUTO) begin
                state_next.dat[AUTO_OFS_LSB +: 8]  = RESULTS.auto_offset;
                state_next.dat[AUTO_GRAD_LSB +: 8] = RESULTS.auto_gradient;
            end else if (idx == IDX_LOST) begin
                state_next.dat[LOST_W-1:0] = state_reg.lost;
            end
        end

        // The counter saturates so a very long on phase cannot wrap into a short one.
        if (!MOTION.pwm_on) begin
            state_next.on_cnt = '0;
        end else if (state_reg.on_cnt != {ON_CNT_W{1'b1}}) begin
            state_next.on_cnt = state_reg.on_cnt + ON_CNT_W'(1);
        end
        state_next.cut  = MOTION.pwm_on && comm_active
            && (state_next.on_cnt >= {{(ON_CNT_W-ON_TIME_W){1'b0}}, on_time_limit});
        state_next.loss = MOTION.pwm_on && loss_enable
            && (state_next.on_cnt >= loss_cycles);

        if (step_edge && comm_active && !MOTION.commutation_ready_output
            && MOTION.step_direction_select) begin
            if (MOTION.dir) begin
                state_next.lost = state_reg.lost - LOST_W'(1);
            end else begin
                state_next.lost = state_reg.lost + LOST_W'(1);
            end
        end

        // Negative half is the ones' complement, so the trough is -248.
        if (TABLE_POS[TAB_IDX_W-1]) begin
            state_next.tab = ~{1'b0, mag};
        end else begin
            state_next.tab = {1'b0, mag};
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            state_reg           <= '0;
            state_reg.chop      <= CHOP_RST;
            state_reg.cool      <= COOL_RST;
            state_reg.comm      <= COMM_RST;
            state_reg.vpwm      <= VPWM_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign WB_ACK                  = state_reg.ack;
    assign WB_DAT_O                = state_reg.dat;
    assign CHOP_CONFIG             = state_reg.chop;
    assign COOL_CONFIG             = state_reg.cool;
    assign VPWM_CONFIG             = state_reg.vpwm;
    assign TABLE_VALUE             = state_reg.tab;
    assign PWM_ON_CUT              = state_reg.cut;
    assign STEP_LOSS_DETECTED      = state_reg.loss;
    assign COMMUTATION_MODE_ACTIVE = comm_active;
    assign STEP_LOSS_DETECT_ENABLE = loss_enable;

endmodule : sdrs_regs

`default_nettype wire

//--- sdrs_host_model.sv
// Host model: classic Wishbone master issuing single register cycles.
`timescale 1ns/1ps
`default_nettype none
module sdrs_host_model (
    input  wire logic                   clk,
    input  wire logic                   ack,
    input  wire logic [31:0]            dat_i,
    output var  sdrs_pkg::sdrs_wb_req_t req,
    output var  logic                   tmo
);
    import sdrs_pkg::*;
    initial req = '0;
    initial tmo = 1'b0;
    // The request stands until ack is sampled or 16 cycles pass without it, which raises tmo.
    task automatic xfer(input logic w, input logic [6:0] idx, input logic [31:0] d,
                        input logic [3:0] s, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{1'b1, 1'b1, w, {idx, 2'b00}, s, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 16);
        tmo <= (ack !== 1'b1);
        q = dat_i;
        req.cyc <= 1'b0;
        req.stb <= 1'b0;
    endtask : xfer
endmodule : sdrs_host_model
`default_nettype wire

//--- sdrs_regs_sva.sv
// Concurrent checks on the ports of the register set.
`timescale 1ns/1ps
`default_nettype none
module sdrs_regs_sva #(
    parameter int TAB_IDX_W = 10
) (
    input wire logic                   SYS_CLK,
    input wire logic                   RST,
    input wire sdrs_pkg::sdrs_wb_req_t WB_REQ,
    input wire logic                   WB_ACK,
    input wire logic [31:0]            WB_DAT_O,
    input wire sdrs_pkg::sdrs_result_t RESULTS,
    input wire sdrs_pkg::sdrs_motion_t MOTION,
    input wire logic [TAB_IDX_W-1:0]   TABLE_POS,
    input wire logic [8:0]             TABLE_VALUE,
    input wire logic [31:0]            CHOP_CONFIG,
    input wire logic                   COMMUTATION_MODE_ACTIVE,
    input wire logic                   STEP_LOSS_DETECT_ENABLE,
    input wire logic                   PWM_ON_CUT
);
    import sdrs_pkg::*;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    sequence s_take(logic w, logic [ADR_W-1:0] a);
        WB_REQ.cyc && WB_REQ.stb && !WB_ACK && WB_REQ.we == w && WB_REQ.adr == a;
    endsequence
    a_ack_answers: assert property (WB_REQ.cyc && WB_REQ.stb && !WB_ACK |=> WB_ACK)
        else $error("request not acknowledged after one cycle");
    a_ack_pulse: assert property (WB_ACK |=> !WB_ACK)
        else $error("acknowledge longer than one cycle");
    a_dat_idle: assert property (!WB_ACK |-> WB_DAT_O == 32'h00000000)
        else $error("read data not zero outside acknowledge");
    a_ampl_read: assert property (s_take(1'b0, 9'h1C4) |=> WB_DAT_O == {7'h00,
        $past(RESULTS.ampl_offset), 8'h00, $past(RESULTS.ampl_scale)})
        else $error("amplitude result read wrong");
    a_auto_read: assert property (s_take(1'b0, 9'h1C8) |=> WB_DAT_O == {8'h00,
        $past(RESULTS.auto_gradient), 8'h00, $past(RESULTS.auto_offset)})
        else $error("tuning result read wrong");
    a_flags_read: assert property (s_take(1'b0, 9'h1BC) |=> WB_DAT_O == $past(RESULTS.load_flags))
        else $error("status read wrong");
    a_chop_write: assert property (s_take(1'b1, 9'h1B0) ##0 WB_REQ.sel == 4'hF |=>
        CHOP_CONFIG == $past(WB_REQ.dat))
        else $error("chopper word write lost");
    a_mode_enable: assert property (COMMUTATION_MODE_ACTIVE == (MOTION.commutation_mode_enable_pin
        || (MOTION.commutation_mode_min_velocity != 0
        && MOTION.velocity >= MOTION.commutation_mode_min_velocity)))
        else $error("commutation mode enable wrong");
    a_loss_cause: assert property (STEP_LOSS_DETECT_ENABLE |-> COMMUTATION_MODE_ACTIVE
        || (MOTION.high_velocity_fullstep && MOTION.velocity >= MOTION.high_velocity_threshold))
        else $error("step-loss detection enabled without cause");
    a_cut_cause: assert property (PWM_ON_CUT |-> $past(MOTION.pwm_on)
        && $past(COMMUTATION_MODE_ACTIVE))
        else $error("on-time cut without on phase");
    a_table_sign: assert property (!$past(RST) |-> TABLE_VALUE[8] == $past(TABLE_POS[9]))
        else $error("table sign does not follow half wave");
endmodule : sdrs_regs_sva
bind sdrs_regs sdrs_regs_sva #(.TAB_IDX_W(TAB_IDX_W)) i_sva (.SYS_CLK(SYS_CLK), .RST(RST),
    .WB_REQ(WB_REQ), .WB_ACK(WB_ACK), .WB_DAT_O(WB_DAT_O), .RESULTS(RESULTS),
    .MOTION(MOTION), .TABLE_POS(TABLE_POS), .TABLE_VALUE(TABLE_VALUE),
    .CHOP_CONFIG(CHOP_CONFIG), .COMMUTATION_MODE_ACTIVE(COMMUTATION_MODE_ACTIVE),
    .STEP_LOSS_DETECT_ENABLE(STEP_LOSS_DETECT_ENABLE), .PWM_ON_CUT(PWM_ON_CUT));
`default_nettype wire

//--- sdrs_regs_tb_top.sv
// Self-checking bench of the register set with random and corner-case traffic.
`timescale 1ns/1ps
`default_nettype none
module sdrs_regs_tb_top;
    import sdrs_pkg::*;
    logic         sys_clk = 1'b0;
    logic         rst     = 1'b1;
    sdrs_wb_req_t req;
    logic         ack, tmo, cut, loss_det, comm_act, loss_en;
    logic [31:0]  dat_o, chop, vpwm, q, v, e, x = 32'd29;
    logic [24:0]  cool;
    logic [8:0]   tab;
    logic [3:0]   s;
    logic [9:0]   pos = '0;
    logic [6:0]   zr [5] = '{IDX_COOL, IDX_COMM, IDX_VPWM, 7'h74, 7'h6B};
    sdrs_result_t res = '0;
    sdrs_motion_t mot = '0;
    int           n_errors = 0, checked = 0, i, mx = -999, mn = 999;
    always #20 sys_clk = ~sys_clk;
    sdrs_host_model i_host (.clk(sys_clk), .ack(ack), .dat_i(dat_o), .req(req), .tmo(tmo));
    sdrs_regs #(.TAB_IDX_W(10)) i_dut (.SYS_CLK(sys_clk), .RST(rst), .WB_REQ(req),
        .WB_ACK(ack), .WB_DAT_O(dat_o), .RESULTS(res), .MOTION(mot), .TABLE_POS(pos),
        .TABLE_VALUE(tab), .CHOP_CONFIG(chop), .COOL_CONFIG(cool), .VPWM_CONFIG(vpwm),
        .COMMUTATION_MODE_ACTIVE(comm_act), .STEP_LOSS_DETECT_ENABLE(loss_en),
        .PWM_ON_CUT(cut), .STEP_LOSS_DETECTED(loss_det));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : rnd
    function automatic logic [8:0] sine(input logic [9:0] p);
        real  a;
        int   t;
        a = 3.14159265358979 / 1024.0;
        t = $rtoi($floor(248.0 * $sin(2.0 * a * $itor(p[8:0]) + a) + 0.5)) - 1;
        return p[9] ? 9'(-t - 1) : 9'(t);
    endfunction : sine
    function automatic logic [31:0] merge(input logic [31:0] o, n, input logic [3:0] m);
        for (int b = 0; b < 4; b++) if (m[b]) o[8*b +: 8] = n[8*b +: 8];
        return o;
    endfunction : merge
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
        checked++;
        if (g !== ex) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, g);
        end
    endtask : chk
    task automatic complete_run();
        if (n_errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run
    task automatic wr(input logic [6:0] a, input logic [31:0] d, input logic [3:0] m);
        i_host.xfer(1'b1, a, d, m, q);
    endtask : wr
    task automatic rd(input logic [6:0] a);
        i_host.xfer(1'b0, a, 32'h00000000, 4'hF, q);
    endtask : rd
    task automatic pulse(input logic d, input logic rdy);
        @(posedge sys_clk);
        mot.dir <= d;
        mot.commutation_ready_output <= rdy;
        mot.step <= 1'b1;
        @(posedge sys_clk);
        mot.step <= 1'b0;
    endtask : pulse
    always @(posedge tmo) begin
        n_errors++;
        complete_run();
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        rd(IDX_CHOP);
        chk("chop reset", CHOP_RST, q);
        chk("vpwm reset", VPWM_RST, vpwm);
        e = CHOP_RST;
        for (i = 0; i < 6; i++) begin
            v = rnd();
            s = (i == 0) ? 4'h1 : 4'(rnd());
            e = merge(e, v, s);
            wr(IDX_CHOP, v, s);
            rd(IDX_CHOP);
            chk("chop", e, q);
            chk("chop port", e, chop);
        end
        wr(IDX_VPWM, v, 4'hF);
        chk("vpwm", v, vpwm);
        wr(IDX_COOL, v, 4'hF);
        chk("cool", {7'h00, v[24:0]}, {7'h00, cool});
        foreach (zr[k]) begin
            rd(zr[k]);
            chk("zero read", 32'h00000000, q);
        end
        res <= '{rnd(), 8'(rnd()), 9'(rnd()), 8'(rnd()), 8'(rnd())};
        wr(IDX_FLAGS, rnd(), 4'hF);
        wr(IDX_LOST, rnd(), 4'hF);
        rd(IDX_FLAGS);
        chk("flags", res.load_flags, q);
        rd(IDX_AMPL);
        chk("ampl", {7'h00, res.ampl_offset, 8'h00, res.ampl_scale}, q);
        rd(IDX_AUTO);
        chk("auto", {8'h00, res.auto_gradient, 8'h00, res.auto_offset}, q);
        mot.step_direction_select <= 1'b1;
        mot.commutation_mode_enable_pin <= 1'b1;
        repeat (3) pulse(1'b0, 1'b0);
        pulse(1'b0, 1'b1);
        repeat (5) pulse(1'b1, 1'b0);
        mot.step_direction_select <= 1'b0;
        pulse(1'b0, 1'b0);
        mot.step_direction_select <= 1'b1;
        mot.commutation_mode_enable_pin <= 1'b0;
        pulse(1'b0, 1'b0);
        rd(IDX_LOST);
        chk("lost", 32'h000FFFFE, q);
        mot.commutation_mode_min_velocity <= 23'd100;
        for (i = 0; i < 2; i++) begin
            @(posedge sys_clk);
            mot.velocity <= 23'(99 + i);
            #1;
            chk("comm mode", i, comm_act);
        end
        wr(IDX_COMM, 32'h00010005, 4'hF);
        @(posedge sys_clk);
        mot.pwm_on <= 1'b1;
        for (i = 1; i <= 16; i++) begin
            @(posedge sys_clk);
            #1;
            chk("on cut", i >= 5, cut);
            chk("loss", i >= 16, loss_det);
        end
        chk("loss enable", 1, loss_en);
        @(posedge sys_clk);
        mot.pwm_on <= 1'b0;
        wr(IDX_COMM, 32'h00000005, 4'hF);
        chk("loss off", 0, loss_en);
        wr(IDX_COMM, 32'h00010005, 4'hF);
        mot.commutation_mode_min_velocity <= 23'd0;
        mot.high_velocity_fullstep <= 1'b1;
        mot.high_velocity_threshold <= 23'd50;
        for (i = 0; i < 2; i++) begin
            @(posedge sys_clk);
            mot.velocity <= 23'(49 + i);
            #1;
            chk("high loss", i, loss_en);
        end
        for (i = 0; i < 1024; i++) begin
            @(posedge sys_clk);
            pos <= 10'(i);
            @(posedge sys_clk);
            #1;
            chk("sine", 32'(sine(10'(i))), 32'(tab));
            if ($signed(tab) > mx) mx = $signed(tab);
            if ($signed(tab) < mn) mn = $signed(tab);
        end
        chk("peak", 247, mx);
        chk("trough", -248, mn);
        complete_run();
    end
endmodule : sdrs_regs_tb_top
`default_nettype wire
